// ---- design/cvr_defs.vh ----
// Purpose: constants for the command/address reference-level mode register
// Assumes: six-bit mode register address field, eight-bit operand
// Notes:   definitions only
`ifndef CVR_DEFS_VH
`define CVR_DEFS_VH
`define CVR_MA_W          6
`define CVR_MA_LEVEL      6'h0c
`define CVR_OP_W          8
`define CVR_DQ_W          16
`define CVR_CODE_W        6
`define CVR_CODE_LSB      0
`define CVR_CODE_MSB      5
`define CVR_RANGE_BIT     6
`define CVR_RSVD_BIT      7
`define CVR_CODE_MAX      6'h32
`define CVR_CODE_RESET    6'h1d
`define CVR_RANGE_RESET   1'h1
`define CVR_SETPOINT_WRITE_SELECT_BIT    6
`define CVR_SETPOINT_OPERATE_SELECT_BIT    7
`endif

// ---- design/cvr_setpoint_copy.v ----
// Purpose: one set-point copy of the level code and range bit
// Assumes: write strobe is already qualified by address and write-select
// Notes:   reserved bit is never stored
`timescale 1ns/1ps
`default_nettype none
`include "cvr_defs.vh"
module cvr_setpoint_copy (
  input  wire                   clk,      // command clock
  input  wire                   rst_n,    // async reset, active low
  input  wire                   wr_en,    // write this copy
  input  wire [`CVR_OP_W-1:0]   wr_data,  // operand from the write
  output reg  [`CVR_CODE_W-1:0] code_reg, // stored level code
  output reg                    range_reg // stored range select
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_reg  <= `CVR_CODE_RESET;  // [R2]
      range_reg <= `CVR_RANGE_RESET; // [R3] [R8]
    end else if (wr_en) begin
      // code and range taken together from one write
      code_reg  <= wr_data[`CVR_CODE_MSB:`CVR_CODE_LSB]; // [R2] [R9]
      range_reg <= wr_data[`CVR_RANGE_BIT];              // [R3] [R8]
    end
  end
endmodule // cvr_setpoint_copy
`default_nettype wire

// ---- design/cvr_level_reg.v ----
// Purpose: command/address reference-level mode register, two set points
// Assumes: decoded mode register read/write strobes on the command clock
// Notes:   set-point selects come from the set-point control register
//
// Overview of operation
// R1: only read/write commands with mode register address 0ch reach this register.
// R2: bits 5..0 hold level code; valid 00h..32h; default 1dh.
// R3: bit 6 selects range, 1 upper; upper range after reset.
// R4: a read drives bit n of the register on data line n.
// R5: reserved bit 7 and unused data lines read zero.
// R6: two copies; reads and writes reach the write-selected copy only.
// R7: only the operate-selected copy drives the reference; other copy ignored.
// R8: a written range stays until overwritten or reset.
// R9: controller writes range together with the level code.
// R10: writes to reserved bit 7 are ignored; it reads zero.
// R11: controller avoids reserved codes above 32h.
`timescale 1ns/1ps
`default_nettype none
`include "cvr_defs.vh"
module cvr_level_reg (
  input  wire                   clk,            // command clock
  input  wire                   rst_n,          // async reset, active low
  input  wire                   mrw_en,         // mode_register_write pulse
  input  wire                   mrr_en,         // mode_register_read pulse
  input  wire [`CVR_MA_W-1:0]   ma,             // mode_register_address_field
  input  wire [`CVR_OP_W-1:0]   wr_op,          // register_operand_bit write data
  input  wire [`CVR_OP_W-1:0]   setpoint_ctrl,  // setpoint_control_register value
  output reg  [`CVR_DQ_W-1:0]   rd_dq,          // read data on dq lines
  output reg                    rd_valid,       // read data valid, one cycle
  output reg  [`CVR_CODE_W-1:0] ca_ref_code,    // applied level code
  output reg                    ca_ref_range,   // applied range select
  output reg                    code_reserved   // applied code is reserved
);
  // --------------------------------------------------------------
  // helper functions
  // --------------------------------------------------------------
  // one copy out of two, shared by the read and the operate paths
  function [`CVR_CODE_W-1:0] cvr_pick_code;
    input                   sel;
    input [`CVR_CODE_W-1:0] c0;
    input [`CVR_CODE_W-1:0] c1;
    begin
      cvr_pick_code = sel ? c1 : c0;
    end
  endfunction

  function cvr_pick_range;
    input sel;
    input r0;
    input r1;
    begin
      cvr_pick_range = sel ? r1 : r0;
    end
  endfunction

  // address compare, shared by both strobes
  function cvr_addr_hit;
    input [`CVR_MA_W-1:0] addr;
    begin
      cvr_addr_hit = (addr == `CVR_MA_LEVEL); // [R1]
    end
  endfunction

  // pack the stored fields onto the data lines
  function [`CVR_DQ_W-1:0] cvr_pack_read;
    input                   rng;
    input [`CVR_CODE_W-1:0] code;
    begin
      cvr_pack_read                              = {`CVR_DQ_W{1'b0}}; // [R5]
      cvr_pack_read[`CVR_CODE_MSB:`CVR_CODE_LSB] = code;              // [R4]
      cvr_pack_read[`CVR_RANGE_BIT]              = rng;               // [R4]
      cvr_pack_read[`CVR_RSVD_BIT]               = 1'b0;              // [R10]
    end
  endfunction

  // reserved codes are only flagged; behaviour for them is undefined
  function cvr_code_is_rsvd;
    input [`CVR_CODE_W-1:0] code;
    begin
      cvr_code_is_rsvd = (code > `CVR_CODE_MAX); // [R11]
    end
  endfunction

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  wire                   wr_sel;
  wire                   op_sel;
  wire                   wr_hit;
  wire                   rd_hit;
  wire                   wr_en0;
  wire                   wr_en1;
  wire [`CVR_CODE_W-1:0] code0;
  wire [`CVR_CODE_W-1:0] code1;
  wire                   rng0;
  wire                   rng1;
  wire [`CVR_CODE_W-1:0] rd_code;
  wire                   rd_range;
  wire [`CVR_CODE_W-1:0] op_code;
  wire                   op_range;
  reg  [`CVR_DQ_W-1:0]   rd_dq_reg;
  reg  [`CVR_DQ_W-1:0]   rd_dq_next;
  reg                    rd_valid_reg;
  reg                    rd_valid_next;
  reg  [`CVR_CODE_W-1:0] ref_code_reg;
  reg  [`CVR_CODE_W-1:0] ref_code_next;
  reg                    ref_range_reg;
  reg                    ref_range_next;
  reg                    rsvd_reg;
  reg                    rsvd_next;

  // --------------------------------------------------------------
  // decode
  // --------------------------------------------------------------
  assign wr_sel = setpoint_ctrl[`CVR_SETPOINT_WRITE_SELECT_BIT]; // [R6]
  assign op_sel = setpoint_ctrl[`CVR_SETPOINT_OPERATE_SELECT_BIT]; // [R7]
  assign wr_hit = mrw_en & cvr_addr_hit(ma);      // [R1]
  assign rd_hit = mrr_en & cvr_addr_hit(ma);      // [R1]
  assign wr_en0 = wr_hit & ~wr_sel;               // [R6]
  assign wr_en1 = wr_hit & wr_sel;                // [R6]

  // --------------------------------------------------------------
  // two set-point copies
  // --------------------------------------------------------------
  cvr_setpoint_copy u_sp0 (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_en0), // [R6]
    .wr_data   (wr_op),
    .code_reg  (code0),
    .range_reg (rng0)
  );

  cvr_setpoint_copy u_sp1 (
    .clk       (clk),
    .rst_n     (rst_n),
    .wr_en     (wr_en1), // [R6]
    .wr_data   (wr_op),
    .code_reg  (code1),
    .range_reg (rng1)
  );

  // --------------------------------------------------------------
  // read path and applied value
  // --------------------------------------------------------------
  // reads return the pre-write copy when a read and write coincide
  assign rd_code  = cvr_pick_code(wr_sel, code0, code1);  // [R6]
  assign rd_range = cvr_pick_range(wr_sel, rng0, rng1);   // [R6]
  assign op_code  = cvr_pick_code(op_sel, code0, code1);  // [R7]
  assign op_range = cvr_pick_range(op_sel, rng0, rng1);   // [R7]

  always @* begin
    rd_valid_next  = rd_hit;                              // [R4]
    rd_dq_next     = {`CVR_DQ_W{1'b0}};                   // [R5]
    if (rd_hit) begin
      rd_dq_next = cvr_pack_read(rd_range, rd_code);      // [R4] [R5] [R10]
    end
    ref_code_next  = op_code;                             // [R7]
    ref_range_next = op_range;                            // [R7]
    rsvd_next      = cvr_code_is_rsvd(op_code);           // [R11]
  end

  // --------------------------------------------------------------
  // registers
  // --------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_dq_reg <= {`CVR_DQ_W{1'b0}};
    end else begin
      rd_dq_reg <= rd_dq_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid_reg <= 1'b0;
    end else begin
      rd_valid_reg <= rd_valid_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_code_reg <= `CVR_CODE_RESET;   // [R2]
    end else begin
      ref_code_reg <= ref_code_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_range_reg <= `CVR_RANGE_RESET; // [R3]
    end else begin
      ref_range_reg <= ref_range_next;
    end
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rsvd_reg <= 1'b0;
    end else begin
      rsvd_reg <= rsvd_next;
    end
  end

  // --------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------
  // plain wiring: every output still comes straight from a flip-flop
  always @* begin
    rd_dq         = rd_dq_reg;
    rd_valid      = rd_valid_reg;
    ca_ref_code   = ref_code_reg;
    ca_ref_range  = ref_range_reg;
    code_reserved = rsvd_reg;
  end

endmodule // cvr_level_reg
`default_nettype wire

// ---- tb/cvr_level_reg_asserts.sv ----
// Purpose: port checks for cvr_level_reg
// Assumes: one clock, async reset
// Notes: bind at foot
`timescale 1ns/1ps
`default_nettype none
module cvr_asserts (
  input wire logic clk, rst_n, mrw_en, mrr_en, rd_valid, ca_ref_range, code_reserved,
  input wire logic [5:0] ma, ca_ref_code,
  input wire logic [7:0] wr_op, setpoint_ctrl,
  input wire logic [15:0] rd_dq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_hit(e); e && ma == 6'h0c; endsequence
  sequence s_hold; !mrw_en && $stable(setpoint_ctrl); endsequence
  a_rd_pulse: assert property (s_hit(mrr_en) |=> rd_valid) else $error("no read");
  a_rd_stray: assert property (!(mrr_en && ma == 6'h0c) |=> !rd_valid) else $error("rd");
  a_rd_rsvd: assert property (rd_valid |-> rd_dq[15:7] == 9'h000) else $error("dq");
  a_idle_dq: assert property (!rd_valid |-> rd_dq == 16'h0000) else $error("idle");
  a_rst_dflt: assert property ($rose(rst_n) |-> {ca_ref_range, ca_ref_code} == 7'h5d)
    else $error("dflt");
  a_rsv_flag: assert property (code_reserved == (ca_ref_code > 6'h32)) else $error("rsv");
  a_wr_apply: assert property (s_hit(mrw_en && setpoint_ctrl[6] == setpoint_ctrl[7]) ##1 s_hold
    |=> {ca_ref_range, ca_ref_code} == $past(wr_op[6:0], 2)) else $error("apply");
  a_wr_ignore: assert property (s_hit(mrw_en && setpoint_ctrl[6] != setpoint_ctrl[7]) ##1 s_hold
    |=> $stable({ca_ref_range, ca_ref_code})) else $error("inactive");
endmodule // cvr_asserts
bind cvr_level_reg cvr_asserts u_chk (.clk, .rst_n, .mrw_en, .mrr_en, .rd_valid, .ca_ref_range,
  .code_reserved, .ma, .ca_ref_code, .wr_op, .setpoint_ctrl, .rd_dq);
`default_nettype wire

// ---- tb/cvr_host_model.sv ----
// Purpose: host issuing mode register commands
// Assumes: lines move 1 ns after the edge
// Notes: released strobes drop to zero; ma and wr_op show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module cvr_host_model (
  input wire logic clk, output var logic mrw_en, mrr_en,
  output var logic [5:0] ma, output var logic [7:0] wr_op
);
  initial {mrw_en, mrr_en, ma, wr_op} = 16'h0000;
  // code and range leave in one operand; operand sent as given, with no code check
  task automatic cmd(input logic wr, input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 {mrw_en, mrr_en, ma, wr_op} = {wr, !wr, a, d};
    @(posedge clk);
    #1 {mrw_en, mrr_en, ma, wr_op} = {2'b00, ~a, ~d};
  endtask
endmodule // cvr_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// Purpose: self-checking bench for cvr_level_reg
// Assumes: 8 ns clock
// Notes: row = {op sel, wr sel, operand, read, applied}
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module tb;
  logic clk, rst_n, mrw_en, mrr_en, rd_valid, rng, rsv;
  logic [5:0] ma, code;
  logic [7:0] wr_op, sc;
  logic [15:0] rd_dq;
  int errors = 0, tests_run = 0;
  logic [23:0] rows [4] = '{{2'b00, 8'ha5, 7'h25, 7'h25}, {2'b01, 8'h72, 7'h72, 7'h25},
    {2'b11, 8'h40, 7'h40, 7'h40}, {2'b10, 8'h00, 7'h00, 7'h40}};
  cvr_level_reg uut (.clk, .rst_n, .mrw_en, .mrr_en, .ma, .wr_op, .setpoint_ctrl(sc), .rd_dq,
    .rd_valid, .ca_ref_code(code), .ca_ref_range(rng), .code_reserved(rsv));
  cvr_host_model host (.clk, .mrw_en, .mrr_en, .ma, .wr_op);
  task automatic print_verdict;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic rd_chk(input logic [6:0] e);
    host.cmd(1'b0, 6'h0c, 8'h00);
    `CHK("rd_valid", 1'b1, rd_valid)
    `CHK("rd_dq", {9'h000, e}, rd_dq)
  endtask
  initial begin clk = 1'b0; forever #4 clk = ~clk; end
  initial begin #20000; errors++; print_verdict; end
  initial begin
    rst_n = 1'b0;
    sc = 8'h00;
    repeat (4) @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("dflt", 8'h5d, {rsv, rng, code})
    foreach (rows[i]) begin
      sc = {rows[i][23:22], 6'h15};
      host.cmd(1'b1, 6'h0c, rows[i][21:14]);
      rd_chk(rows[i][13:7]);
      `CHK("applied", rows[i][6:0], {rng, code})
    end
    host.cmd(1'b1, 6'h0d, 8'h3f);
    rd_chk(7'h00);
    rst_n = 1'b0;
    @(posedge clk);
    #1 rst_n = 1'b1;
    `CHK("rst", 8'h5d, {rsv, rng, code})
    rd_chk(7'h5d);
    print_verdict;
  end
endmodule // tb
`default_nettype wire
